// [design/cbl_pkg.sv]
// shared constants for the channel self-test, loopback and link-fault block
package cbl_pkg;
	// apb register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	// control register field positions
	localparam int CTL_SELFTEST = 0;
	localparam int CTL_LOOPBACK = 1;
	localparam int CTL_RXSEL    = 2;
	localparam int CTL_RXEN     = 3;
	localparam int CTL_REFMODE  = 4;
	localparam int CTL_RATE     = 5;
	localparam int CTL_SPEED    = 6;
	localparam int CTL_AMP      = 8;
	localparam int CTL_DRV_A    = 10;
	localparam int CTL_DRV_B    = 11;
	localparam int CTL_WIDTH    = 12;
	// control value after reset: self-test off, drivers off
	localparam logic [11:0] CTRL_RESET = 12'h000;
	// self-test sequence lengths in characters
	localparam logic [9:0] PATTERN_CHARS = 10'h1FF;
	localparam logic [9:0] SYNC_CHARS    = 10'h010;
	// lfsr preset and fill character
	localparam logic [8:0] LFSR_PRESET = 9'h1FF;
	localparam logic [9:0] FILL_CHAR   = 10'h17C;
	// transition density limit in static characters
	localparam logic [2:0] DENSITY_CHARS = 3'h6;
	// range control sampling period in receive characters
	localparam logic [11:0] RANGE_PERIOD = 12'hFFF;
	localparam logic [4:0]  FORCE_CHARS  = 5'h10;
	// reference clock watchdog in system cycles
	localparam logic [7:0] REF_TIMEOUT = 8'h40;
	// system clock and settle time
	localparam int CLK_PERIOD_PS  = 5000;
	localparam int SETTLE_TIME_US = 250;
	localparam int SETTLE_CYCLES  = SETTLE_TIME_US * 1000000 / CLK_PERIOD_PS;
	// self-test sequencer states
	typedef enum logic [1:0] {
		BIST_IDLE = 2'b00,
		BIST_SYNC = 2'b01,
		BIST_PAT  = 2'b10
	} cbl_bist_t;
endpackage

// [design/cbl_top.sv]
// one transceiver channel: self-test, loopback, drivers, link fault
//
// What this block does
// - self-test turns transmit register into 511 lfsr
// - reset disables self-test on every channel
// - self-test ignores parallel byte and control
// - reference mode prefixes each pass with sync
// - rate select picks times 10 or 20
// - speed select picks one of three ranges
// - loopback forces enabled drivers to static one
// - loopback feeds transmit data to own receiver
// - loopback fault uses only range and density
// - drivers enabled singly, channel powers down
// - reset disables every serial driver
// - re-enabled channel flags out-of-spec settle time
// - receiver select picks one of two inputs
// - link valid only when all conditions hold
// - link fault changes only on receive clock
// - amplitude select 00 off, else threshold
// - amplitude monitor watches only selected receiver
// - fault after more than six static characters
// - disabled recovery shows constant link fault
// - out of range forces oscillator, fault low
//
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

// three-stage input synchroniser, change taken when stages two and three agree
module cbl_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         arst_n_i,
	input  wire logic [W-1:0] d_i,
	output var  logic [W-1:0] q_o
);
	logic [W-1:0] s1_reg; // first stage, read by s2 only
	logic [W-1:0] s2_reg;
	logic [W-1:0] s3_reg;

	// shift chain and per-bit agreement filter
	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
			q_o    <= '0;
		end else begin
			s1_reg <= d_i;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			q_o    <= (q_o & ~(s2_reg ^ s3_reg)) | (q_o & (s2_reg ^ s3_reg));
			for (int i = 0; i < W; i++) begin
				if (s2_reg[i] == s3_reg[i]) begin
					q_o[i] <= s3_reg[i];
				end
			end
		end
	end
endmodule // cbl_sync

module cbl_top import cbl_pkg::*; #(
	parameter int SETTLE_CYC = SETTLE_CYCLES // shorten in simulation
) (
	// clock and reset
	input  wire logic        CLK_SYS_I,
	input  wire logic        ARST_N_I,
	// apb slave
	input  wire logic        PSEL_I,
	input  wire logic        PENABLE_I,
	input  wire logic        PWRITE_I,
	input  wire logic [7:0]  PADDR_I,
	input  wire logic [31:0] PWDATA_I,
	output logic      [31:0] PRDATA_O,
	output logic             PREADY_O,
	output logic             PSLVERR_O,
	// transmit side
	input  wire logic        CHANNEL_REFERENCE_CLOCK_I,
	input  wire logic [7:0]  TX_PARALLEL_BYTE_I,
	input  wire logic [1:0]  TX_CHAR_CONTROL_I,
	output logic             TX_CHAR_CLOCK_OUT_O,
	output logic      [9:0]  TX_CHAR_O,
	output logic             TX_CLOCK_MULTIPLIER_SELECT_O,
	output logic      [1:0]  SPEED_RANGE_SELECT_O,
	output logic             DRIVER_A_ENABLE_O,
	output logic             DRIVER_B_ENABLE_O,
	output logic             DRIVER_FORCE_ONE_O,
	output logic             CHANNEL_POWER_DOWN_O,
	output logic             TX_SETTLING_O,
	// receive side
	input  wire logic        RX_CHAR_CLOCK_I,
	input  wire logic [9:0]  PRIMARY_SERIAL_INPUT_I,
	input  wire logic [9:0]  SECONDARY_SERIAL_INPUT_I,
	input  wire logic [1:0]  PRIMARY_AMPLITUDE_I,
	input  wire logic [1:0]  SECONDARY_AMPLITUDE_I,
	input  wire logic        RX_FREQ_IN_RANGE_I,
	input  wire logic        EXTERNAL_LINK_CONDITION_I,
	output logic             LINE_RECEIVER_SELECT_O,
	output logic             LOCAL_LOOPBACK_ENABLE_O,
	output logic             RX_RECOVERY_ENABLE_O,
	output logic             RX_VCO_FORCE_O,
	output logic      [1:0]  AMPLITUDE_THRESHOLD_SELECT_O,
	output logic             LINK_FAULT_INDICATOR_N_O
);
	logic [CTL_WIDTH-1:0] ctrl_reg;      // software control word
	logic [27:0]          pin_s;         // synchronised pin inputs
	logic                 ref_s;         // reference clock level
	logic                 rxclk_s;       // receive char clock level
	logic [9:0]           pri_s;
	logic [9:0]           sec_s;
	logic [1:0]           pamp_s;
	logic [1:0]           samp_s;
	logic                 freq_s;
	logic                 ext_s;
	logic                 ref_d_reg;     // edge history
	logic                 rxclk_d_reg;
	logic                 tx_tick;       // one character time
	logic                 rx_tick;       // receive clock rising
	logic                 drv_on;
	logic                 drv_on_d_reg;
	cbl_bist_t            bist_reg;
	logic [9:0]           cnt_reg;       // characters sent in phase
	logic [8:0]           lfsr_reg;
	logic [9:0]           char_reg;
	logic                 clkout_reg;
	logic [31:0]          settle_reg;
	logic [7:0]           ref_wd_reg;    // cycles since last ref edge
	logic                 ref_ok;
	logic [9:0]           rx_char;       // character seen by recovery
	logic                 last_bit_reg;
	logic [2:0]           static_reg;    // static character run
	logic                 dens_fault;
	logic [11:0]          range_reg;
	logic [4:0]           force_reg;
	logic                 amp_ok;
	logic [1:0]           amp_lvl;
	logic                 link_ok;
	logic                 lfi_n_reg;
	logic                 apb_wr;
	logic                 hit;

	cbl_sync #(.W(28)) u_sync (
		.clk_i   (CLK_SYS_I),
		.arst_n_i(ARST_N_I),
		.d_i     ({CHANNEL_REFERENCE_CLOCK_I, RX_CHAR_CLOCK_I, PRIMARY_SERIAL_INPUT_I,
			SECONDARY_SERIAL_INPUT_I, PRIMARY_AMPLITUDE_I, SECONDARY_AMPLITUDE_I,
			RX_FREQ_IN_RANGE_I, EXTERNAL_LINK_CONDITION_I}),
		.q_o     (pin_s)
	);
	assign {ref_s, rxclk_s, pri_s, sec_s, pamp_s, samp_s, freq_s, ext_s} = pin_s;

	// apb: zero wait states, unmapped offsets answer with an error
	// status word is read only; writes to it are dropped quietly
	assign hit       = (PADDR_I == CTRL_OFS) || (PADDR_I == STAT_OFS);
	assign PREADY_O  = 1'b1;
	assign PSLVERR_O = PSEL_I & PENABLE_I & ~hit;
	assign apb_wr    = PSEL_I & PENABLE_I & PWRITE_I & (PADDR_I == CTRL_OFS);

	// control register; reset clears self-test and drivers
	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			ctrl_reg <= CTRL_RESET;
		end else if (apb_wr) begin
			ctrl_reg <= PWDATA_I[CTL_WIDTH-1:0];
		end
	end

	// read mux, status word shows live block state
	always_comb begin
		PRDATA_O = '0;
		if (PADDR_I == CTRL_OFS) begin
			PRDATA_O[CTL_WIDTH-1:0] = ctrl_reg;
		end else if (PADDR_I == STAT_OFS) begin
			PRDATA_O[5:0] = {ref_ok, TX_SETTLING_O, amp_ok, dens_fault,
				RX_VCO_FORCE_O, lfi_n_reg};
		end
	end

	// configuration straight to the analog parts
	assign TX_CLOCK_MULTIPLIER_SELECT_O = ctrl_reg[CTL_RATE];
	assign SPEED_RANGE_SELECT_O         = ctrl_reg[CTL_SPEED+:2];
	assign LINE_RECEIVER_SELECT_O       = ctrl_reg[CTL_RXSEL];
	assign LOCAL_LOOPBACK_ENABLE_O      = ctrl_reg[CTL_LOOPBACK];
	assign RX_RECOVERY_ENABLE_O         = ctrl_reg[CTL_RXEN];
	assign AMPLITUDE_THRESHOLD_SELECT_O = ctrl_reg[CTL_AMP+:2];
	assign DRIVER_A_ENABLE_O            = ctrl_reg[CTL_DRV_A];
	assign DRIVER_B_ENABLE_O            = ctrl_reg[CTL_DRV_B];
	assign drv_on                       = DRIVER_A_ENABLE_O | DRIVER_B_ENABLE_O;
	assign CHANNEL_POWER_DOWN_O         = ~drv_on;
	// loopback keeps diagnostics off the line
	assign DRIVER_FORCE_ONE_O = LOCAL_LOOPBACK_ENABLE_O & drv_on;
	assign TX_CHAR_O           = char_reg;
	assign TX_CHAR_CLOCK_OUT_O = clkout_reg;
	assign TX_SETTLING_O       = (settle_reg != 32'h0);
	assign LINK_FAULT_INDICATOR_N_O = lfi_n_reg;

	// character time: each ref rise at x10, each ref edge at x20
	// a stalled reference stops ticks, so the character stream freezes
	assign tx_tick = ctrl_reg[CTL_RATE] ? (ref_s ^ ref_d_reg)
		: (ref_s & ~ref_d_reg);
	assign rx_tick = rxclk_s & ~rxclk_d_reg;

	// edge history and driver enable history
	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			ref_d_reg    <= 1'b0;
			rxclk_d_reg  <= 1'b0;
			drv_on_d_reg <= 1'b0;
		end else begin
			ref_d_reg    <= ref_s;
			rxclk_d_reg  <= rxclk_s;
			drv_on_d_reg <= drv_on;
		end
	end

	// character clock out, one pulse per transmitted character
	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			clkout_reg <= 1'b0;
		end else begin
			clkout_reg <= tx_tick & drv_on;
		end
	end

	// settle window after a fully disabled channel comes back
	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			settle_reg <= 32'h0;
		end else if (drv_on & ~drv_on_d_reg) begin
			settle_reg <= 32'(SETTLE_CYC);
		end else if (settle_reg != 32'h0) begin
			settle_reg <= settle_reg - 32'h1;
		end
	end

	// self-test sequencer, advances one step per character
	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			bist_reg <= BIST_IDLE;
			cnt_reg  <= 10'h000;
			lfsr_reg <= LFSR_PRESET;
		end else if (!ctrl_reg[CTL_SELFTEST]) begin
			bist_reg <= BIST_IDLE;
			cnt_reg  <= 10'h000;
			lfsr_reg <= LFSR_PRESET;
		end else if (tx_tick) begin
			unique case (bist_reg)
				BIST_IDLE: begin
					// reference mode opens with word sync
					bist_reg <= ctrl_reg[CTL_REFMODE] ? BIST_SYNC : BIST_PAT;
					cnt_reg  <= 10'h000;
				end
				BIST_SYNC: begin
					cnt_reg <= cnt_reg + 10'h001;
					if (cnt_reg == SYNC_CHARS - 10'h001) begin
						bist_reg <= BIST_PAT;
						cnt_reg  <= 10'h000;
						lfsr_reg <= LFSR_PRESET;
					end
				end
				BIST_PAT: begin
					// x^9 + x^5 + 1, maximal length 511
					lfsr_reg <= {lfsr_reg[7:0], lfsr_reg[8] ^ lfsr_reg[4]};
					cnt_reg  <= cnt_reg + 10'h001;
					if (cnt_reg == PATTERN_CHARS - 10'h001) begin
						cnt_reg  <= 10'h000;
						lfsr_reg <= LFSR_PRESET;
						if (ctrl_reg[CTL_REFMODE]) begin
							bist_reg <= BIST_SYNC;
						end
					end
				end
				default: bist_reg <= BIST_IDLE;
			endcase
		end
	end

	// transmit character register; power-down holds it at zero
	// stale parallel data never leaks out after power-down
	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			char_reg <= 10'h000;
		end else if (!drv_on) begin
			char_reg <= 10'h000;
		end else if (tx_tick) begin
			if (bist_reg == BIST_SYNC) begin
				char_reg <= FILL_CHAR;
			end else if (bist_reg == BIST_PAT) begin
				// parallel inputs ignored while testing
				char_reg <= {lfsr_reg[0], lfsr_reg};
			end else if (!ctrl_reg[CTL_SELFTEST]) begin
				char_reg <= {TX_CHAR_CONTROL_I, TX_PARALLEL_BYTE_I};
			end
		end
	end

	// reference clock presence watchdog
	// a missing reference leaves the counter parked at its limit
	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			ref_wd_reg <= REF_TIMEOUT;
		end else if (ref_s ^ ref_d_reg) begin
			ref_wd_reg <= 8'h00;
		end else if (ref_wd_reg != REF_TIMEOUT) begin
			ref_wd_reg <= ref_wd_reg + 8'h01;
		end
	end
	assign ref_ok = (ref_wd_reg != REF_TIMEOUT);

	// recovery input: looped transmit data or the selected receiver
	assign rx_char = LOCAL_LOOPBACK_ENABLE_O ? char_reg
		: (LINE_RECEIVER_SELECT_O ? sec_s : pri_s);

	// transition density on the recovered stream
	// counting whole characters is coarser than a bit run, so a
	// fault may need up to two characters more than sixty bits
	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			last_bit_reg <= 1'b0;
			static_reg   <= 3'h0;
		end else if (rx_tick) begin
			last_bit_reg <= rx_char[9];
			if (rx_char == {10{last_bit_reg}}) begin
				// saturate one past the limit
				if (static_reg != DENSITY_CHARS + 3'h1) begin
					static_reg <= static_reg + 3'h1;
				end
			end else begin
				static_reg <= 3'h0;
			end
		end
	end
	assign dens_fault = (static_reg > DENSITY_CHARS);

	// range control: sample every period, force for a short burst
	// free-running count; the rate flag is only looked at on the wrap
	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			range_reg <= 12'h000;
			force_reg <= 5'h00;
		end else if (rx_tick) begin
			range_reg <= range_reg + 12'h001;
			if (force_reg != 5'h00) begin
				force_reg <= force_reg - 5'h01;
			end else if (range_reg == RANGE_PERIOD && !freq_s) begin
				force_reg <= FORCE_CHARS;
			end
		end
	end
	assign RX_VCO_FORCE_O = (force_reg != 5'h00);

	// amplitude against threshold, selected receiver only
	assign amp_lvl = LINE_RECEIVER_SELECT_O ? samp_s : pamp_s;
	assign amp_ok  = LOCAL_LOOPBACK_ENABLE_O
		|| (AMPLITUDE_THRESHOLD_SELECT_O == 2'b00)
		|| (amp_lvl >= AMPLITUDE_THRESHOLD_SELECT_O);

	// every condition must hold; loopback drops the external ones
	assign link_ok = RX_RECOVERY_ENABLE_O & freq_s & ~RX_VCO_FORCE_O
		& ~dens_fault & amp_ok
		& (LOCAL_LOOPBACK_ENABLE_O | (ref_ok & ~ext_s));

	// fault output moves only on receive clock edges
	// the edge detect adds sync delay, so the output lags a few cycles
	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			lfi_n_reg <= 1'b0;
		end else if (rx_tick) begin
			lfi_n_reg <= link_ok;
		end
	end
endmodule // cbl_top

`default_nettype wire

// [tb/cbl_checker.sv]
// port-level assertions for the channel self-test, loopback and link-fault block
`timescale 1ns/1ps
`default_nettype none
module cbl_checker (
	// clock and reset
	input wire logic       CLK_SYS_I,
	input wire logic       ARST_N_I,
	// watched outputs
	input wire logic       TX_CHAR_CLOCK_OUT_O,
	input wire logic [9:0] TX_CHAR_O,
	input wire logic       DRIVER_A_ENABLE_O,
	input wire logic       DRIVER_B_ENABLE_O,
	input wire logic       DRIVER_FORCE_ONE_O,
	input wire logic       CHANNEL_POWER_DOWN_O,
	input wire logic       TX_SETTLING_O,
	input wire logic       LOCAL_LOOPBACK_ENABLE_O,
	input wire logic       RX_RECOVERY_ENABLE_O,
	input wire logic       RX_VCO_FORCE_O,
	input wire logic       LINK_FAULT_INDICATOR_N_O
);
	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (!ARST_N_I);
	// any serial driver switched on
	wire logic drv_on = DRIVER_A_ENABLE_O | DRIVER_B_ENABLE_O;

	a_force_one: assert property (DRIVER_FORCE_ONE_O == (LOCAL_LOOPBACK_ENABLE_O & drv_on))
		else $error("static one output disagrees with loopback and drivers");
	a_power_down: assert property (CHANNEL_POWER_DOWN_O == !drv_on)
		else $error("channel power down disagrees with drivers");
	// a powered-down channel must not keep sending a stale character
	a_char_zero: assert property (CHANNEL_POWER_DOWN_O [*3] |-> TX_CHAR_O == 10'h000)
		else $error("character not cleared while powered down");
	a_pulse_drv: assert property (TX_CHAR_CLOCK_OUT_O |-> !$past(CHANNEL_POWER_DOWN_O))
		else $error("character clock pulse while powered down");
	a_char_holds: assert property ($changed(TX_CHAR_O) |-> TX_CHAR_CLOCK_OUT_O ||
		CHANNEL_POWER_DOWN_O || $past(CHANNEL_POWER_DOWN_O))
		else $error("character changed without a character clock");
	a_fault_en: assert property ($rose(LINK_FAULT_INDICATOR_N_O) |-> $past(RX_RECOVERY_ENABLE_O))
		else $error("link valid with recovery disabled");
	a_fault_force: assert property ($rose(LINK_FAULT_INDICATOR_N_O) |-> !$past(RX_VCO_FORCE_O))
		else $error("link valid while oscillator forced");
	a_settle_start: assert property ($rose(TX_SETTLING_O) |-> $past(CHANNEL_POWER_DOWN_O, 2) && drv_on)
		else $error("settling started without leaving all-off");
endmodule // cbl_checker

bind cbl_top cbl_checker u_cbl_checker (
	.CLK_SYS_I(CLK_SYS_I), .ARST_N_I(ARST_N_I), .TX_CHAR_CLOCK_OUT_O(TX_CHAR_CLOCK_OUT_O),
	.TX_CHAR_O(TX_CHAR_O), .DRIVER_A_ENABLE_O(DRIVER_A_ENABLE_O),
	.DRIVER_B_ENABLE_O(DRIVER_B_ENABLE_O), .DRIVER_FORCE_ONE_O(DRIVER_FORCE_ONE_O),
	.CHANNEL_POWER_DOWN_O(CHANNEL_POWER_DOWN_O), .TX_SETTLING_O(TX_SETTLING_O),
	.LOCAL_LOOPBACK_ENABLE_O(LOCAL_LOOPBACK_ENABLE_O), .RX_VCO_FORCE_O(RX_VCO_FORCE_O),
	.RX_RECOVERY_ENABLE_O(RX_RECOVERY_ENABLE_O),
	.LINK_FAULT_INDICATOR_N_O(LINK_FAULT_INDICATOR_N_O));
`default_nettype wire

// [tb/cbl_partner.sv]
// far-side model: reference clock and received character stream
`timescale 1ns/1ps
`default_nettype none
module cbl_partner (
	// stream control
	input  wire logic       static_i,
	// clocks and characters toward the channel
	output var  logic       ref_clk_o,
	output var  logic       rx_clk_o,
	output var  logic [9:0] pri_o,
	output var  logic [9:0] sec_o
);
	// free-running reference at one fixed rate inside one speed range
	initial begin
		ref_clk_o = 1'b0;
		forever #12 ref_clk_o = ~ref_clk_o;
	end
	// characters move on the falling receive clock; static mode kills transitions
	initial begin
		rx_clk_o = 1'b0;
		pri_o = 10'h155;
		sec_o = 10'h2AA;
		forever begin
			#13 rx_clk_o = 1'b1;
			#13 rx_clk_o = 1'b0;
			pri_o = static_i ? 10'h000 : ~pri_o;
			sec_o = static_i ? 10'h000 : ~sec_o;
		end
	end
endmodule // cbl_partner
`default_nettype wire

// [tb/channel_bist_loopback_link_fault_bench.sv]
// self-checking bench for the channel self-test, loopback and link-fault block
`timescale 1ns/1ps
`default_nettype none
module channel_bist_loopback_link_fault_bench import cbl_pkg::*;;
	logic        clk, arst_n, psel, pen, pwr, xlc, fin, stat, er;
	logic [7:0]  padr, tbyte;
	logic [31:0] pwd, rd;
	logic [1:0]  tctl, pamp, samp;
	logic [9:0]  ch [0:599]; // captured transmit characters
	wire logic        rclk, xclk, prdy, perr, tpl, mul, da, db, f1, pd, st, lp, lfi;
	wire logic        rsel, ren, vf;
	wire logic [31:0] prd;
	wire logic [9:0]  tch, pri, sec;
	wire logic [1:0]  spd, amp;
	int          n_mismatch, checks, cyc;

	// settle count shortened so the run stays short
	cbl_top #(.SETTLE_CYC(20)) u_cbl_top (
		.CLK_SYS_I(clk), .ARST_N_I(arst_n), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
		.PADDR_I(padr), .PWDATA_I(pwd), .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr),
		.CHANNEL_REFERENCE_CLOCK_I(rclk), .TX_PARALLEL_BYTE_I(tbyte), .TX_CHAR_CONTROL_I(tctl),
		.TX_CHAR_CLOCK_OUT_O(tpl), .TX_CHAR_O(tch), .TX_CLOCK_MULTIPLIER_SELECT_O(mul),
		.SPEED_RANGE_SELECT_O(spd), .DRIVER_A_ENABLE_O(da), .DRIVER_B_ENABLE_O(db),
		.DRIVER_FORCE_ONE_O(f1), .CHANNEL_POWER_DOWN_O(pd), .TX_SETTLING_O(st),
		.RX_CHAR_CLOCK_I(xclk), .PRIMARY_SERIAL_INPUT_I(pri), .SECONDARY_SERIAL_INPUT_I(sec),
		.PRIMARY_AMPLITUDE_I(pamp), .SECONDARY_AMPLITUDE_I(samp), .RX_FREQ_IN_RANGE_I(fin),
		.EXTERNAL_LINK_CONDITION_I(xlc), .LINE_RECEIVER_SELECT_O(rsel),
		.RX_RECOVERY_ENABLE_O(ren),
		.LOCAL_LOOPBACK_ENABLE_O(lp), .RX_VCO_FORCE_O(vf), .AMPLITUDE_THRESHOLD_SELECT_O(amp),
		.LINK_FAULT_INDICATOR_N_O(lfi));
	cbl_partner u_cbl_partner (.static_i(stat), .ref_clk_o(rclk), .rx_clk_o(xclk),
		.pri_o(pri), .sec_o(sec));

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// apb transfer: setup, access, wait for ready, then release
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1; pen <= 0; pwr <= w; padr <= a; pwd <= d;
		@(posedge clk);
		pen <= 1;
		@(posedge clk);
		while (prdy !== 1'b1) @(posedge clk);
		rd = prd;
		er = perr;
		psel <= 0; pen <= 0;
		@(posedge clk); // let the written value reach the outputs
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	// the fault output moves only on receive ticks, so allow a bounded wait
	task wlfi(input logic e);
		int k;
		for (k = 0; k < 400 && lfi !== e; k++) @(posedge clk);
		chk("link_fault_n", e, lfi);
	endtask
	task pulse;
		do @(posedge clk); while (tpl !== 1'b1);
	endtask
	task t_reset;
		chk("power_down", 1, pd);
		chk("drivers", 0, {da, db});
		apb(0, CTRL_OFS, 0);
		chk("ctrl", 0, rd);
		apb(0, 8'h0C, 0);
		chk("slverr", 1, er);
		chk("err_data", 0, rd);
	endtask
	task t_map;
		int i;
		logic [31:0] v;
		for (i = 0; i < 12; i++) begin
			v = {22'h0, 2'(i / 3), 2'(i % 3), i[0], 5'h00};
			apb(1, CTRL_OFS, v);
			apb(0, CTRL_OFS, 0);
			chk("ctrl", v, rd);
			chk("speed", i % 3, spd);
			chk("amp_sel", i / 3, amp);
			chk("rate", i[0], mul);
		end
	endtask
	task t_drv;
		int n;
		apb(1, CTRL_OFS, 32'h420);
		// count on falling edges, where the registered flag has settled
		@(negedge clk);
		n = 0;
		while (st === 1'b1 && n < 99) begin n++; @(negedge clk); end
		chk("settle", 20, n);
		chk("power_down", 0, pd);
		apb(1, CTRL_OFS, 32'h822);
		chk("force_one", 1, f1);
		chk("loopback", 1, lp);
		apb(1, CTRL_OFS, 32'h022);
		chk("force_one", 0, f1);
		chk("power_down", 1, pd);
	endtask
	task t_data;
		apb(1, CTRL_OFS, 32'h420);
		tbyte <= 8'hA5; tctl <= 2'h2;
		pulse; pulse; pulse;
		chk("char", 10'h2A5, tch);
	endtask
	// self-test with sync prefix; the parallel byte keeps changing meanwhile
	task t_bist;
		int i, s, bad;
		logic [8:0] q;
		apb(1, CTRL_OFS, 32'h431);
		for (i = 0; i < 600; i++) begin pulse; ch[i] = tch; tbyte <= ~tbyte; end
		s = 0;
		bad = 0;
		while (ch[s] !== FILL_CHAR && s < 50) s++;
		for (i = s; i < s + 16; i++) bad += (ch[i] !== FILL_CHAR);
		chk("sync_run", 0, bad);
		bad = 0;
		for (i = s + 16; i < s + 526; i++) begin
			q = {ch[i][7:0], ch[i][8] ^ ch[i][4]};
			bad += (ch[i+1] !== {q[0], q});
		end
		chk("lfsr_steps", 0, bad);
		chk("next_sync", FILL_CHAR, ch[s+527]);
	endtask
	task t_link;
		apb(1, CTRL_OFS, 32'h528);
		wlfi(1);
		xlc <= 1; wlfi(0);
		xlc <= 0; wlfi(1);
		fin <= 0; wlfi(0);
		fin <= 1; wlfi(1);
		pamp <= 0; wlfi(0);
		apb(1, CTRL_OFS, 32'h52C); // secondary receiver, low amplitude
		chk("rx_select", 1, rsel);
		samp <= 2'h3; wlfi(1);
		stat <= 1; wlfi(0);
		stat <= 0; wlfi(1);
		samp <= 0; wlfi(0);
		apb(1, CTRL_OFS, 32'h52B); wlfi(1);
		apb(1, CTRL_OFS, 32'h523); wlfi(0);
		chk("rx_enable", 0, ren);
	endtask
	// range control: hold the rate flag low until a forcing burst starts
	task t_force;
		int k;
		apb(1, CTRL_OFS, 32'h528);
		chk("rx_select", 0, rsel);
		chk("rx_enable", 1, ren);
		pamp <= 2'h1;
		wlfi(1);
		fin <= 0;
		k = 0;
		while (vf !== 1'b1 && k < 30000) begin k++; @(posedge clk); end
		chk("vco_force", 1, vf);
		fin <= 1;
		repeat (20) @(posedge clk);
		chk("vco_force", 1, vf);
		chk("link_fault_n", 0, lfi);
		k = 0;
		while (vf !== 1'b0 && k < 200) begin k++; @(posedge clk); end
		chk("vco_force", 0, vf);
		wlfi(1);
	endtask
	task summarize;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	// hang guard well above the expected run length
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin n_mismatch++; summarize; end
	end
	initial begin
		arst_n = 0; psel = 0; pen = 0; pwr = 0; padr = 0; pwd = 0; tbyte = 0; tctl = 0;
		pamp = 2'h1; samp = 0; xlc = 0; fin = 1; stat = 0; n_mismatch = 0; checks = 0; cyc = 0;
		repeat (3) @(posedge clk);
		arst_n <= 1;
		@(posedge clk);
		t_reset; $display("reset test done");
		t_map; $display("field map test done");
		t_drv; $display("driver test done");
		t_data; $display("data path test done");
		t_bist; $display("self-test done");
		t_link; $display("link fault test done");
		t_force; $display("range control test done");
		summarize;
	end
endmodule // channel_bist_loopback_link_fault_bench
`default_nettype wire
